//--- logic/dcp_top.sv
/*
 * display command page control: target address, pixel widening,
 * sleep-exit reload control, active set status and page select.
 * assumes a decoded serial front end presenting one-cycle request pulses
 * on ref_clk, and sleep_exit / sw_reset as same-domain one-cycle pulses.
 */
// How it works
// - seven-bit programmable target address in bits 6:0, bit 7 reads zero, resets zero.
// - accesses to global target zero or the programmed target are accepted.
// - mode 00 widens by replicating top bits; eight-bit passes through.
// - mode 01 pads low bits with zeros.
// - reload bit zero reloads lane, standby, 3D settings; one keeps them.
// - leaving sleep reloads nonvolatile-backed settings unless reload bit is one.
// - reset values come from the store when programmed, else defaults.
// - status is one-hot, bit 0 base set, bits 1-5 pages, resets 01h.
// - page select 00h base set, 01h-05h pages zero to four, resets 00h.
// - a page select write of 00h-05h updates page_sel and status only; register decode ignores the page.
`timescale 1ns/1ns
`default_nettype none
module dcp_top
    import dcp_pkg::*;
#(
    parameter dcp_nv_t NV_DEFAULT = '0
)(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic sw_reset,
    // register requests
    input wire dcp_req_t req,
    // power state events
    input wire logic sleep_exit,
    // nonvolatile store
    input wire logic nv_programmed,
    input wire dcp_nv_t nv_values,
    // software-written settings
    input wire logic nv_load,
    input wire dcp_nv_t nv_sw_values,
    // pixel path
    input wire dcp_fmt_t pix_fmt,
    input wire dcp_pixel_t pix_in,
    output logic [7:0] pix_r,
    output logic [7:0] pix_g,
    output logic [7:0] pix_b,
    // register read answer
    output logic rd_valid,
    output logic [7:0] rd_data,
    // state
    output logic [5:0] active_set_status,
    output logic [7:0] page_sel,
    output dcp_nv_t nv_settings,
    output logic addr_hit
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [6:0] target;
        dcp_widen_t widen;
        logic keep_settings_on_wake;
        logic [7:0] page;
        logic [5:0] status;
        dcp_nv_t nv;
        logic rd_valid;
        logic [7:0] rd_data;
        logic hit;
        dcp_pixel_t pix;
        logic boot;
    } dcp_state_t;

    dcp_state_t st_r;
    dcp_state_t st_nxt;
    logic [1:0] rst_sync_r;
    logic rst_n_int;
    logic hit_now;
    logic [7:0] wide_r;
    logic [7:0] wide_g;
    logic [7:0] wide_b;
    dcp_nv_t reload_val;

    // ----------------------------------------
    // reset release
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n_int = rst_sync_r[1];

    // ----------------------------------------
    // widening, one instance per component
    // ----------------------------------------
    dcp_widen u_wr (.mode(st_r.widen), .fmt(pix_fmt), .five_bit(1'b1),
        .comp_in(pix_in.r), .comp_out(wide_r));
    dcp_widen u_wg (.mode(st_r.widen), .fmt(pix_fmt), .five_bit(1'b0),
        .comp_in(pix_in.g), .comp_out(wide_g));
    dcp_widen u_wb (.mode(st_r.widen), .fmt(pix_fmt), .five_bit(1'b1),
        .comp_in(pix_in.b), .comp_out(wide_b));

    // store contents stand in for defaults once programmed
    assign reload_val = nv_programmed ? nv_values : NV_DEFAULT;
    assign hit_now = (req.target == DCP_GLOBAL_TARGET) || (req.target == st_r.target);

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.rd_valid = 1'b0;
        st_nxt.hit = hit_now && (req.wr || req.rd);
        st_nxt.pix = '{r: wide_r, g: wide_g, b: wide_b};
        st_nxt.boot = 1'b0;
        if (nv_load) begin
            st_nxt.nv = nv_sw_values;
        end
        // keep bit one holds software values over the wake
        if (sleep_exit && !st_r.keep_settings_on_wake) begin
            st_nxt.nv = reload_val;
        end
        if (req.wr && hit_now) begin
            case (req.addr)
                DCP_OFS_TARGET_ADDR: st_nxt.target = req.data[6:0];
                DCP_OFS_PIXEL_WIDEN: st_nxt.widen = dcp_widen_t'(req.data[1:0]);
                DCP_OFS_RELOAD_CTRL: st_nxt.keep_settings_on_wake = req.data[0];
                DCP_OFS_PAGE_SELECT: begin
                    // unlisted page codes are ignored so status stays one-hot
                    if (req.data <= DCP_PAGE_MAX) begin
                        st_nxt.page = req.data;
                        st_nxt.status = 6'(1 << req.data[2:0]);
                    end
                end
                default: st_nxt.target = st_r.target;
            endcase
        end
        if (req.rd && hit_now) begin
            st_nxt.rd_valid = 1'b1;
            case (req.addr)
                DCP_OFS_TARGET_ADDR: st_nxt.rd_data = {1'b0, st_r.target};
                DCP_OFS_PIXEL_WIDEN: st_nxt.rd_data = {6'h00, st_r.widen};
                DCP_OFS_RELOAD_CTRL: st_nxt.rd_data = {7'h00, st_r.keep_settings_on_wake};
                DCP_OFS_SET_STATUS: st_nxt.rd_data = {2'h0, st_r.status};
                default: st_nxt.rd_data = DCP_READ_ZERO;
            endcase
        end
        // store is sampled at the first clock after release, never while in reset
        if (st_r.boot) begin
            st_nxt.nv = reload_val;
        end
        // software reset restores defaults; settings come from the store if programmed
        if (sw_reset) begin
            st_nxt = '0;
            st_nxt.status = DCP_STATUS_RST;
            st_nxt.page = DCP_PAGE_RST;
            st_nxt.target = DCP_TARGET_RST;
            st_nxt.widen = dcp_widen_t'(DCP_WIDEN_RST);
            st_nxt.keep_settings_on_wake = DCP_KEEP_RST;
            st_nxt.nv = reload_val;
        end
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            st_r <= '0;
            st_r.status <= DCP_STATUS_RST;
            st_r.page <= DCP_PAGE_RST;
            st_r.target <= DCP_TARGET_RST;
            st_r.widen <= dcp_widen_t'(DCP_WIDEN_RST);
            st_r.keep_settings_on_wake <= DCP_KEEP_RST;
            st_r.nv <= NV_DEFAULT;
            st_r.boot <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign pix_r = st_r.pix.r;
    assign pix_g = st_r.pix.g;
    assign pix_b = st_r.pix.b;
    assign rd_valid = st_r.rd_valid;
    assign rd_data = st_r.rd_data;
    assign active_set_status = st_r.status;
    assign page_sel = st_r.page;
    assign nv_settings = st_r.nv;
    assign addr_hit = st_r.hit;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_status_onehot: assert property (@(posedge ref_clk) disable iff (!rst_n_int)
        $onehot(st_r.status)) else $error("status not one-hot");
    a_page_status_tie: assert property (@(posedge ref_clk) disable iff (!rst_n_int)
        st_r.status == 6'(1 << st_r.page[2:0])) else $error("status off page");
    a_page_write: assert property (@(posedge ref_clk) disable iff (!rst_n_int)
        req.wr && hit_now && !sw_reset && req.addr == DCP_OFS_PAGE_SELECT
        && req.data <= DCP_PAGE_MAX |=> page_sel == $past(req.data))
        else $error("page select lost");
    a_global_hit: assert property (@(posedge ref_clk) disable iff (!rst_n_int)
        req.rd && req.target == DCP_GLOBAL_TARGET && !sw_reset |=> rd_valid)
        else $error("global target refused");
    a_target_bit7: assert property (@(posedge ref_clk) disable iff (!rst_n_int)
        rd_valid && $past(req.addr) == DCP_OFS_TARGET_ADDR |-> !rd_data[7])
        else $error("target bit 7 set");
    a_keep_hold: assert property (@(posedge ref_clk) disable iff (!rst_n_int)
        sleep_exit && st_r.keep_settings_on_wake && !nv_load && !sw_reset
        |=> st_r.nv == $past(st_r.nv)) else $error("settings reloaded");
    a_wake_reload: assert property (@(posedge ref_clk) disable iff (!rst_n_int)
        sleep_exit && !st_r.keep_settings_on_wake |=> st_r.nv == $past(reload_val))
        else $error("wake reload missed");
    a_boot_load: assert property (@(posedge ref_clk) disable iff (!rst_n_int)
        st_r.boot |=> st_r.nv == $past(reload_val))
        else $error("boot load missed");
    a_widen_rep: assert property (@(posedge ref_clk) disable iff (!rst_n_int)
        st_r.widen == DCP_WIDEN_REPLICATE && pix_fmt == DCP_FMT_565
        |=> pix_r[2:0] == pix_r[7:5]) else $error("replicate wrong");
    a_widen_zero: assert property (@(posedge ref_clk) disable iff (!rst_n_int)
        st_r.widen == DCP_WIDEN_ZERO && pix_fmt == DCP_FMT_666
        |=> pix_g[1:0] == 2'h0) else $error("zero pad wrong");
endmodule
`default_nettype wire

//--- logic/dcp_pkg.sv
/*
 * package for the display command page control block: register map,
 * field layouts, reset values, pixel widening modes and state types.
 * assumes nothing beyond a single 25 MHz clock domain.
 */
package dcp_pkg;
    // ----------------------------------------
    // register offsets
    // ----------------------------------------
    localparam logic [7:0] DCP_OFS_TARGET_ADDR = 8'hf8;
    localparam logic [7:0] DCP_OFS_PIXEL_WIDEN = 8'hf9;
    localparam logic [7:0] DCP_OFS_RELOAD_CTRL = 8'hfb;
    localparam logic [7:0] DCP_OFS_SET_STATUS = 8'hfe;
    localparam logic [7:0] DCP_OFS_PAGE_SELECT = 8'hff;
    // ----------------------------------------
    // reset values and fixed codes
    // ----------------------------------------
    localparam logic [6:0] DCP_GLOBAL_TARGET = 7'h00;
    localparam logic [6:0] DCP_TARGET_RST = 7'h00;
    localparam logic [1:0] DCP_WIDEN_RST = 2'h0;
    localparam logic DCP_KEEP_RST = 1'b0;
    localparam logic [7:0] DCP_PAGE_RST = 8'h00;
    localparam logic [7:0] DCP_PAGE_MAX = 8'h05;
    localparam logic [5:0] DCP_STATUS_RST = 6'h01;
    localparam logic [7:0] DCP_READ_ZERO = 8'h00;
    // ----------------------------------------
    // nonvolatile-backed settings width
    // ----------------------------------------
    localparam int DCP_NV_W = 8;
    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [1:0] {
        DCP_WIDEN_REPLICATE = 2'b00,
        DCP_WIDEN_ZERO = 2'b01,
        DCP_WIDEN_ONES = 2'b10,
        DCP_WIDEN_NONE = 2'b11
    } dcp_widen_t;
    typedef enum logic [1:0] {
        DCP_FMT_565 = 2'b00,
        DCP_FMT_666 = 2'b01,
        DCP_FMT_888 = 2'b10,
        DCP_FMT_RSV = 2'b11
    } dcp_fmt_t;
    typedef struct packed {
        logic [7:0] r;
        logic [7:0] g;
        logic [7:0] b;
    } dcp_pixel_t;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [6:0] target;
        logic [7:0] addr;
        logic [7:0] data;
    } dcp_req_t;
    typedef struct packed {
        logic [DCP_NV_W-1:0] lane;
        logic [DCP_NV_W-1:0] standby;
        logic [DCP_NV_W-1:0] three_d;
    } dcp_nv_t;
endpackage

//--- logic/dcp_widen.sv
/*
 * widens one colour component to eight bits.
 * assumes the component sits in the low bits of comp_in.
 */
`timescale 1ns/1ns
`default_nettype none
module dcp_widen
    import dcp_pkg::*;
(
    // selection
    input wire dcp_widen_t mode,
    input wire dcp_fmt_t fmt,
    input wire logic five_bit,
    // data
    input wire logic [7:0] comp_in,
    output logic [7:0] comp_out
);
    // ----------------------------------------
    // widening
    // ----------------------------------------
    always_comb begin
        comp_out = comp_in;
        if (fmt != DCP_FMT_888) begin
            if (five_bit && fmt == DCP_FMT_565) begin
                case (mode)
                    DCP_WIDEN_REPLICATE: comp_out = {comp_in[4:0], comp_in[4:2]};
                    DCP_WIDEN_ZERO: comp_out = {comp_in[4:0], 3'h0};
                    DCP_WIDEN_ONES: comp_out = {comp_in[4:0], 3'h7};
                    default: comp_out = {comp_in[4:0], 3'h0};
                endcase
            end else begin
                case (mode)
                    DCP_WIDEN_REPLICATE: comp_out = {comp_in[5:0], comp_in[5:4]};
                    DCP_WIDEN_ZERO: comp_out = {comp_in[5:0], 2'h0};
                    DCP_WIDEN_ONES: comp_out = {comp_in[5:0], 2'h3};
                    default: comp_out = {comp_in[5:0], 2'h0};
                endcase
            end
        end
    end
endmodule
`default_nettype wire

//--- verification/dcp_host.sv
/*
 * host model: issues single-byte register requests to the block.
 * assumes one 25 MHz ref_clk and the one-cycle request pulses of dcp_top.
 */
`timescale 1ns/1ns
`default_nettype none
module dcp_host
    import dcp_pkg::*;
(
    // clock
    input wire logic ref_clk,
    // request and answer
    output var dcp_req_t req,
    input wire logic rd_valid,
    input wire logic [7:0] rd_data,
    input wire logic addr_hit
);
    // ----------------------------------------
    // request cycle
    // ----------------------------------------
    initial req = '0;
    // only used in normal or sleep-in states; wr and most reads call it with the global target 00h
    task automatic xfer(input logic wr, input logic [6:0] tgt, input logic [7:0] a,
                        input logic [7:0] d, output logic ok, output logic [7:0] dat,
                        output logic hit);
        @(posedge ref_clk);
        #1;
        req = '{wr: wr, rd: !wr, target: tgt, addr: a, data: d};
        @(posedge ref_clk);
        #1;
        ok = rd_valid;
        dat = rd_data;
        hit = addr_hit;
        // released fields show the inverse so a stale copy cannot pass
        req = '{wr: 1'b0, rd: 1'b0, target: ~tgt, addr: ~a, data: ~d};
    endtask
endmodule
`default_nettype wire

//--- verification/display_driver_command_page_control_test.sv
/*
 * self-checking bench for dcp_top with a host model on the request port.
 * assumes the dcp_pkg register map and one 25 MHz clock.
 */
`timescale 1ns/1ns
`default_nettype none
module display_driver_command_page_control_test;
    import dcp_pkg::*;
    localparam dcp_nv_t NVD = 24'h5a3c69;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic sw_reset = 1'b0, sleep_exit = 1'b0, nv_load = 1'b0, nv_programmed = 1'b1;
    dcp_nv_t nv_values = 24'hc3a5f0, nv_sw_values = 24'h0f1e2d, nv_settings;
    dcp_fmt_t pix_fmt = DCP_FMT_565;
    dcp_pixel_t pix_in = 24'h132d0e;
    dcp_req_t req;
    logic [7:0] pix_r, pix_g, pix_b, rd_data, page_sel;
    logic [5:0] active_set_status;
    logic rd_valid, addr_hit;
    int mismatches = 0;
    int cmp_count = 0;
    always #20 ref_clk = ~ref_clk;
    dcp_host i_dcp_host (.ref_clk(ref_clk), .req(req), .rd_valid(rd_valid),
        .rd_data(rd_data), .addr_hit(addr_hit));
    dcp_top #(.NV_DEFAULT(NVD)) i_dcp_top (.ref_clk(ref_clk), .rst_b(rst_b),
        .sw_reset(sw_reset), .req(req), .sleep_exit(sleep_exit),
        .nv_programmed(nv_programmed), .nv_values(nv_values), .nv_load(nv_load),
        .nv_sw_values(nv_sw_values), .pix_fmt(pix_fmt), .pix_in(pix_in), .pix_r(pix_r),
        .pix_g(pix_g), .pix_b(pix_b), .rd_valid(rd_valid), .rd_data(rd_data),
        .active_set_status(active_set_status), .page_sel(page_sel),
        .nv_settings(nv_settings), .addr_hit(addr_hit));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic tick;
        @(posedge ref_clk);
        #1;
    endtask
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_set(input logic [23:0] got, input logic [23:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic ok, hit;
        logic [7:0] dat;
        i_dcp_host.xfer(1'b1, 7'h00, a, d, ok, dat, hit);
    endtask
    // read and check the answer; e of 1 means the target must be accepted, e of 0 that it is refused with no answer
    task automatic rd_chk(input logic [6:0] t, input logic [7:0] a, input logic [7:0] exp,
                          input logic e);
        logic ok, hit;
        logic [7:0] dat;
        i_dcp_host.xfer(1'b0, t, a, 8'h00, ok, dat, hit);
        check_byte({ok, hit, 6'h0}, {e, e, 6'h0});
        if (e) check_byte(dat, exp);
    endtask
    // select 1 load, 2 sleep exit, 4 software reset
    task automatic pulse(input logic [2:0] k);
        {sw_reset, sleep_exit, nv_load} = k;
        tick;
        {sw_reset, sleep_exit, nv_load} = 3'h0;
        tick;
    endtask
    function automatic logic [7:0] widen(input logic [1:0] m, input logic [7:0] c, input int n);
        if (n == 8) return c;
        if (n == 5) return m == 2'b00 ? {c[4:0], c[4:2]} : m == 2'b01 ? {c[4:0], 3'h0} :
            {c[4:0], 3'h7};
        return m == 2'b00 ? {c[5:0], c[5:4]} : m == 2'b01 ? {c[5:0], 2'h0} : {c[5:0], 2'h3};
    endfunction
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic reset_values;
        rd_chk(7'h00, DCP_OFS_TARGET_ADDR, 8'h00, 1'b1);
        rd_chk(7'h00, DCP_OFS_PIXEL_WIDEN, 8'h00, 1'b1);
        rd_chk(7'h00, DCP_OFS_RELOAD_CTRL, 8'h00, 1'b1);
        rd_chk(7'h00, DCP_OFS_SET_STATUS, 8'h01, 1'b1);
        check_byte(page_sel, 8'h00);
        check_set(nv_settings, nv_values);
    endtask
    task automatic target_addr;
        wr(DCP_OFS_TARGET_ADDR, 8'ha5);
        rd_chk(7'h00, DCP_OFS_TARGET_ADDR, 8'h25, 1'b1);
        rd_chk(7'h25, DCP_OFS_SET_STATUS, 8'h01, 1'b1);
        rd_chk(7'h11, DCP_OFS_SET_STATUS, 8'h01, 1'b0);
    endtask
    task automatic pages;
        for (int p = 0; p < 6; p++) begin
            wr(DCP_OFS_PAGE_SELECT, 8'(p));
            check_byte(page_sel, 8'(p));
            check_byte({2'h0, active_set_status}, 8'(1 << p));
            rd_chk(7'h00, DCP_OFS_SET_STATUS, 8'(1 << p), 1'b1);
        end
        wr(DCP_OFS_PAGE_SELECT, 8'h06);
        rd_chk(7'h00, DCP_OFS_SET_STATUS, 8'h20, 1'b1);
        wr(DCP_OFS_SET_STATUS, 8'h01);
        rd_chk(7'h00, DCP_OFS_SET_STATUS, 8'h20, 1'b1);
    endtask
    task automatic widening;
        // mode 11 is never written: the host keeps clear of it
        for (int m = 0; m < 3; m++) begin
            wr(DCP_OFS_PIXEL_WIDEN, 8'(m));
            rd_chk(7'h00, DCP_OFS_PIXEL_WIDEN, 8'(m), 1'b1);
            for (int f = 0; f < 3; f++) begin
                pix_fmt = dcp_fmt_t'(f);
                tick;
                tick;
                check_byte(pix_r, widen(2'(m), 8'h13, f == 2 ? 8 : f == 0 ? 5 : 6));
                check_byte(pix_g, widen(2'(m), 8'h2d, f == 2 ? 8 : 6));
                check_byte(pix_b, widen(2'(m), 8'h0e, f == 2 ? 8 : f == 0 ? 5 : 6));
            end
        end
    endtask
    task automatic reload;
        nv_programmed = 1'b1;
        pulse(3'h1);
        check_set(nv_settings, nv_sw_values);
        pulse(3'h2);
        check_set(nv_settings, nv_values);
        wr(DCP_OFS_RELOAD_CTRL, 8'h01);
        rd_chk(7'h00, DCP_OFS_RELOAD_CTRL, 8'h01, 1'b1);
        pulse(3'h1);
        pulse(3'h2);
        check_set(nv_settings, nv_sw_values);
        pulse(3'h4);
        check_set(nv_settings, nv_values);
        rd_chk(7'h00, DCP_OFS_TARGET_ADDR, 8'h00, 1'b1);
        rd_chk(7'h00, DCP_OFS_SET_STATUS, 8'h01, 1'b1);
        nv_programmed = 1'b0;
        pulse(3'h4);
        check_set(nv_settings, NVD);
        pulse(3'h1);
        pulse(3'h2);
        check_set(nv_settings, NVD);
    endtask
    // ----------------------------------------
    // verdict and main sequence
    // ----------------------------------------
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge ref_clk);
        #1;
        rst_b = 1'b1;
        repeat (4) tick;
        reset_values();
        target_addr();
        pages();
        widening();
        reload();
        give_verdict();
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        mismatches++;
        give_verdict();
    end
endmodule
`default_nettype wire
